// file: rtl/ahbp_consts.svh
// Constants of the asynchronous host bus port
`ifndef AHBP_CONSTS_SVH
`define AHBP_CONSTS_SVH

`define AHBP_DATA_W 28
`define AHBP_HALF_W 16
`define AHBP_ADDR_W 4
`define AHBP_ADDR_FIFO 4'h8
`define AHBP_ADDR_MODE 4'hE
`define AHBP_MODE_HALF 28'h0000010
`define AHBP_UPPER_IGN 4
`define AHBP_SYNC_LEN 3
`define AHBP_CLK_PS 40000
`define AHBP_T_RFS_PS 27000
`define AHBP_T_RRS_PS 13000
// Least times round up to whole cycles
`define AHBP_RFS_CYC ((`AHBP_T_RFS_PS + `AHBP_CLK_PS - 1) / `AHBP_CLK_PS)
`define AHBP_RRS_CYC ((`AHBP_T_RRS_PS + `AHBP_CLK_PS - 1) / `AHBP_CLK_PS)
`define AHBP_CNT_W 4
`define AHBP_BUF_DEPTH 2
`define AHBP_CTRL_IDLE 5'h1E

`endif

// file: rtl/ahbp_pkg.sv
// Types of the asynchronous host bus port
`include "ahbp_consts.svh"
package ahbp_pkg;
  typedef logic [`AHBP_DATA_W-1:0] ahbp_word_t;
  typedef logic [`AHBP_ADDR_W-1:0] ahbp_addr_t;
  typedef enum logic [2:0] {
    AHBP_ST_IDLE = 3'b001,
    AHBP_ST_READ = 3'b010,
    AHBP_ST_WRITE = 3'b100
  } ahbp_state_t;
endpackage

// file: rtl/ahbp_stream_if.sv
// Word stream between the buffer and the port logic
`timescale 1ns/1ps
`default_nettype none
interface ahbp_stream_if;
  logic valid;
  logic ready;
  ahbp_pkg::ahbp_word_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: rtl/ahbp_buf2.sv
// Two-entry buffer on the readout data path
`timescale 1ns/1ps
`default_nettype none
`include "ahbp_consts.svh"
module ahbp_buf2 (
  // Clock, enable, reset
  input wire logic clk_sys,
  input wire logic ce,
  input wire logic srst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire ahbp_pkg::ahbp_word_t in_data,
  // Draining side
  ahbp_stream_if.src out
);
  import ahbp_pkg::*;
  ahbp_word_t mem [`AHBP_BUF_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  wire push = in_valid && in_ready;
  wire pop = out.valid && out.ready;

  assign in_ready = (count != 2'h2);
  assign out.valid = (count != 2'h0);
  assign out.data = mem[rd_ptr];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else if (ce) begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// file: rtl/ahbp_port.sv
// Asynchronous host bus port: strobe capture, half-word pairing, hit blanking
// How it works
// [R1] Host never reads the FIFO while empty.
// [R2] Drive select low: data drivers always on.
// [R3] Drive select high: drive only during read.
// [R4] Host keeps drive select high when writing.
// [R5] Read data held until the next read.
// [R6] Host may add a delayed dummy read.
// [R7] Writing 0x10 to address 14 selects halves.
// [R8] Half mode: host accesses always in pairs.
// [R9] First access lower half, second upper half.
// [R10] Top four upper bits ignored both ways.
// [R11] Empty updates after first read of pair.
// [R12] Host completes second read after empty change.
// [R13] Hits blanked at least 27 ns after rise.
// [R14] Hits resume at least 13 ns after fall.
// [R15] Four-bit address, select, read, write strobes.
// [R16] Full 28-bit width after reset.
`timescale 1ns/1ps
`default_nettype none
`include "ahbp_consts.svh"
module ahbp_port (
  // Clock, enable, reset
  input wire logic clk_sys,
  input wire logic ce,
  input wire logic srst,
  // Host bus pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire ahbp_pkg::ahbp_addr_t addr,
  input wire logic output_drive_select,
  input wire ahbp_pkg::ahbp_word_t data_in,
  output ahbp_pkg::ahbp_word_t data_out,
  output logic data_oe,
  output logic fifo_empty,
  // Master reset pin and hit gate
  input wire logic master_reset,
  output logic hit_accept,
  // Readout stream from the core
  input wire logic core_valid,
  output logic core_ready,
  input wire ahbp_pkg::ahbp_word_t core_data,
  // Register access towards the core
  output logic reg_wr,
  output ahbp_pkg::ahbp_addr_t reg_addr,
  output ahbp_pkg::ahbp_word_t reg_wdata,
  input wire ahbp_pkg::ahbp_word_t reg_rdata,
  // Mode status
  output logic half_mode
);
  import ahbp_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int NSYNC = 5 + `AHBP_ADDR_W + `AHBP_DATA_W;
  logic [NSYNC-1:0] sy1;
  logic [NSYNC-1:0] sy2;
  logic [NSYNC-1:0] sy3;
  logic [NSYNC-1:0] flt;
  wire [NSYNC-1:0] pin_vec = {cs_n, rd_n, wr_n, output_drive_select, master_reset, addr, data_in};
  wire [NSYNC-1:0] agree = ~(sy2 ^ sy3);
  // All stages start at the idle pin levels, so reset brings no false edge
  localparam logic [NSYNC-1:0] PIN_IDLE = {`AHBP_CTRL_IDLE, {(NSYNC-5){1'b0}}};

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sy1 <= PIN_IDLE;
      sy2 <= PIN_IDLE;
      sy3 <= PIN_IDLE;
      flt <= PIN_IDLE;
    end else if (ce) begin
      sy1 <= pin_vec;
      sy2 <= sy1;
      sy3 <= sy2;
      flt <= (agree & sy3) | (~agree & flt);
    end
  end

  wire s_cs_n = flt[NSYNC-1];
  wire s_rd_n = flt[NSYNC-2];
  wire s_wr_n = flt[NSYNC-3];
  wire s_ods = flt[NSYNC-4];
  wire s_mrst = flt[NSYNC-5];
  wire [`AHBP_ADDR_W-1:0] s_addr = flt[`AHBP_DATA_W +: `AHBP_ADDR_W];
  wire [`AHBP_DATA_W-1:0] s_data = flt[`AHBP_DATA_W-1:0];

  // ****************************************************************
  // Strobe decode
  // ****************************************************************
  wire rd_act = !s_cs_n && !s_rd_n; // [R15]
  wire wr_act = !s_cs_n && !s_wr_n && s_ods; // [R4] [R15]
  wire is_fifo = (s_addr == `AHBP_ADDR_FIFO);
  ahbp_state_t state;
  ahbp_state_t next_state;
  wire rd_start = (state == AHBP_ST_IDLE) && rd_act;
  wire wr_done = (state == AHBP_ST_WRITE) && !wr_act;

  always_comb begin
    next_state = state;
    unique case (state)
      AHBP_ST_IDLE: begin
        if (rd_act) begin
          next_state = AHBP_ST_READ;
        end else if (wr_act) begin
          next_state = AHBP_ST_WRITE;
        end
      end
      AHBP_ST_READ: begin
        if (!rd_act) begin
          next_state = AHBP_ST_IDLE;
        end
      end
      AHBP_ST_WRITE: begin
        if (!wr_act) begin
          next_state = AHBP_ST_IDLE;
        end
      end
    endcase
  end

  // ****************************************************************
  // Readout buffer
  // ****************************************************************
  ahbp_stream_if rbuf ();
  ahbp_buf2 u_buf (
    .clk_sys(clk_sys),
    .ce(ce),
    .srst(srst),
    .in_valid(core_valid),
    .in_ready(core_ready),
    .in_data(core_data),
    .out(rbuf.src)
  );

  // ****************************************************************
  // Pairing and data path
  // ****************************************************************
  logic second; // Next access is the upper half
  ahbp_word_t rd_hold;
  logic [`AHBP_HALF_W-1:0] wr_low;
  wire wide_rd = half_mode && second;
  wire fetch = rd_start && !wide_rd; // New word on every full read or lower half
  wire pop_word = fetch && is_fifo && rbuf.valid; // [R1]
  assign rbuf.ready = pop_word;
  wire [`AHBP_DATA_W-1:0] fetched = is_fifo ? rbuf.data : reg_rdata;
  wire [`AHBP_DATA_W-1:0] lower_half_word = {{(`AHBP_DATA_W-`AHBP_HALF_W){1'b0}},
    fetched[`AHBP_HALF_W-1:0]}; // [R9]
  wire [`AHBP_DATA_W-1:0] upper_half_word = {{`AHBP_HALF_W{1'b0}},
    rd_hold[`AHBP_DATA_W-1:`AHBP_HALF_W]}; // [R10]
  wire [`AHBP_DATA_W-1:0] full_wdata = half_mode ?
    {s_data[`AHBP_HALF_W-`AHBP_UPPER_IGN-1:0], wr_low} : s_data; // [R9] [R10]
  wire wr_commit = wr_done && (!half_mode || second); // [R8]
  wire mode_wr = wr_commit && (s_addr == `AHBP_ADDR_MODE);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= AHBP_ST_IDLE;
      second <= 1'b0;
      half_mode <= 1'b0; // [R16]
      rd_hold <= '0;
      wr_low <= '0;
      data_out <= '0;
      reg_wr <= 1'b0;
      reg_addr <= '0;
      reg_wdata <= '0;
    end else if (ce) begin
      state <= next_state;
      reg_wr <= 1'b0;
      if (fetch) begin
        rd_hold <= fetched;
        data_out <= half_mode ? lower_half_word : fetched; // [R9]
      end else if (rd_start) begin
        data_out <= upper_half_word; // [R9] [R10]
      end
      if (half_mode && (rd_start || wr_done)) begin
        second <= ~second; // [R8] [R9]
      end
      if (wr_done && half_mode && !second) begin
        wr_low <= s_data[`AHBP_HALF_W-1:0]; // [R9]
      end
      if (wr_commit) begin
        reg_wr <= 1'b1;
        reg_addr <= s_addr;
        reg_wdata <= full_wdata;
      end
      if (mode_wr) begin
        half_mode <= (full_wdata == `AHBP_MODE_HALF); // [R7]
        second <= 1'b0;
      end
    end
  end

  // Empty follows the buffer, so it moves right after the lower-half pop
  assign fifo_empty = !rbuf.valid; // [R11]
  // Register hold keeps data valid for as long as the drivers stay on
  assign data_oe = !s_ods || (state == AHBP_ST_READ); // [R2] [R3] [R5]

  // ****************************************************************
  // Hit blanking around master reset
  // ****************************************************************
  logic [`AHBP_CNT_W-1:0] blank_cnt;
  logic mrst_d;
  wire mrst_rise = s_mrst && !mrst_d;
  wire mrst_fall = !s_mrst && mrst_d;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mrst_d <= 1'b0;
      blank_cnt <= '0;
    end else if (ce) begin
      mrst_d <= s_mrst;
      if (mrst_rise) begin
        blank_cnt <= `AHBP_CNT_W'(`AHBP_RFS_CYC); // [R13]
      end else if (mrst_fall) begin
        blank_cnt <= (blank_cnt > `AHBP_CNT_W'(`AHBP_RRS_CYC)) ? blank_cnt :
          `AHBP_CNT_W'(`AHBP_RRS_CYC); // [R14]
      end else if (blank_cnt != '0) begin
        blank_cnt <= blank_cnt - `AHBP_CNT_W'(1);
      end
    end
  end

  assign hit_accept = !s_mrst && !mrst_d && (blank_cnt == '0); // [R13] [R14]
endmodule
`default_nettype wire

// file: tb/ahbp_host_model.sv
// Host controller model that drives the port pins
`timescale 1ns/1ps
`default_nettype none
`include "ahbp_consts.svh"
module ahbp_host_model (
  // Clock and device outputs
  input wire logic clk_sys,
  input wire ahbp_pkg::ahbp_word_t data_out,
  input wire logic data_oe,
  input wire logic fifo_empty,
  // Host pins
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output ahbp_pkg::ahbp_addr_t addr,
  output logic output_drive_select,
  output ahbp_pkg::ahbp_word_t data_in,
  // Set when a read with ce set hits an empty FIFO
  output logic bad_rd
);
  import ahbp_pkg::*;
  // ********
  // Accesses
  // ********
  initial begin
    {cs_n, rd_n, wr_n, output_drive_select, bad_rd} = 5'h1E;
    addr = 4'h0;
    data_in = 28'h0;
  end
  task automatic acc(input logic wr, input ahbp_addr_t a, input ahbp_word_t d,
      input logic ods, input logic ce, output ahbp_word_t q, output logic oe);
    @(negedge clk_sys);
    if (ce && !wr && a == `AHBP_ADDR_FIFO && fifo_empty) bad_rd = 1'b1;
    addr = a;
    output_drive_select = ods;
    if (wr) data_in = d;
    {cs_n, rd_n, wr_n} = {1'b0, wr, !wr};
    repeat (6) @(negedge clk_sys);
    q = data_out;
    oe = data_oe;
    {cs_n, rd_n, wr_n} = 3'h7;
    // Released bus shows garbage once hold time is over
    repeat (4) @(negedge clk_sys);
    data_in = ~data_in;
    repeat (3) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// file: tb/ahbp_port_assertions.sv
// Checker of the host bus port
`timescale 1ns/1ps
`default_nettype none
`include "ahbp_consts.svh"
module ahbp_port_chk (
  // Watched ports
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic output_drive_select,
  input wire ahbp_pkg::ahbp_word_t data_out,
  input wire logic data_oe,
  input wire logic fifo_empty,
  input wire logic master_reset,
  input wire logic hit_accept,
  input wire logic reg_wr,
  input wire ahbp_pkg::ahbp_addr_t reg_addr,
  input wire ahbp_pkg::ahbp_word_t reg_wdata,
  input wire logic half_mode
);
  import ahbp_pkg::*;
  wire mode_wr = reg_wr && reg_addr == `AHBP_ADDR_MODE;
  // **********
  // Assertions
  // **********
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_reset_state: assert property ($fell(srst) |-> !half_mode && fifo_empty)
    else $error("state after reset wrong");
  a_drive_always: assert property (!output_drive_select [*6] |-> data_oe)
    else $error("bus not driven with drive select low");
  a_drive_off: assert property ((output_drive_select && rd_n) [*6] |-> !data_oe)
    else $error("bus driven without read");
  a_drive_read: assert property ((!cs_n && !rd_n && output_drive_select) [*6] |-> data_oe)
    else $error("bus not driven during read");
  a_data_hold: assert property ((cs_n && rd_n) [*6] |=> $stable(data_out))
    else $error("read data changed without read");
  a_mode_set: assert property (mode_wr && reg_wdata == `AHBP_MODE_HALF |->
    ##[0:2] half_mode)
    else $error("half mode not entered");
  a_mode_clear: assert property (mode_wr && reg_wdata != `AHBP_MODE_HALF |->
    ##[0:2] !half_mode)
    else $error("half mode not left");
  a_blank_on: assert property (master_reset [*5] |-> !hit_accept)
    else $error("hits accepted in master reset");
  a_blank_off: assert property (!master_reset [*7] |-> hit_accept)
    else $error("hits still blanked");
  a_write_pulse: assert property (reg_wr |=> !reg_wr)
    else $error("write pulse too long");
  c_half: cover property ($rose(half_mode));
  c_blank: cover property ($fell(hit_accept));
  c_write: cover property (reg_wr);
endmodule
bind ahbp_port ahbp_port_chk u_chk (.clk_sys, .srst, .cs_n, .rd_n, .output_drive_select,
  .data_out, .data_oe, .fifo_empty, .master_reset, .hit_accept, .reg_wr, .reg_addr,
  .reg_wdata, .half_mode);
`default_nettype wire

// file: tb/async_host_bus_port_tb_top.sv
// Bench for the host bus port
`timescale 1ns/1ps
`default_nettype none
`include "ahbp_consts.svh"
module async_host_bus_port_tb_top;
  import ahbp_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic core_valid = 1'b0;
  logic master_reset = 1'b0;
  logic ce = 1'b1;
  logic cs_n, rd_n, wr_n, ods, data_oe, fifo_empty, hit_accept;
  logic core_ready, reg_wr, half_mode, bad_rd, oe;
  ahbp_addr_t addr, reg_addr, wa;
  ahbp_word_t core_data = 28'h0, reg_rdata = 28'h1234567;
  ahbp_word_t data_in, data_out, reg_wdata, wd, q;
  int fails = 0, compares = 0, wcnt = 0;
  ahbp_port dut (.clk_sys, .ce, .srst, .cs_n, .rd_n, .wr_n, .addr,
    .output_drive_select(ods), .data_in, .data_out, .data_oe, .fifo_empty, .master_reset,
    .hit_accept, .core_valid, .core_ready, .core_data, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .half_mode);
  ahbp_host_model host (.clk_sys, .data_out, .data_oe, .fifo_empty, .cs_n, .rd_n, .wr_n,
    .addr, .output_drive_select(ods), .data_in, .bad_rd);
  // *******
  // Helpers
  // *******
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (reg_wr === 1'b1) begin
      wcnt <= wcnt + 1;
      wa <= reg_addr;
      wd <= reg_wdata;
    end
  end
  task automatic chk(input string n, input ahbp_word_t e, input ahbp_word_t g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input ahbp_addr_t a, input logic o, input logic ce);
    host.acc(1'b0, a, 28'h0, o, ce, q, oe);
  endtask
  task automatic wr(input ahbp_addr_t a, input ahbp_word_t d, input logic o);
    host.acc(1'b1, a, d, o, 1'b0, q, oe);
  endtask
  task automatic push(input ahbp_word_t w);
    @(negedge clk_sys);
    core_valid = 1'b1;
    core_data = w;
    @(negedge clk_sys);
    core_valid = 1'b0;
  endtask
  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic t_fill();
    push(28'h0000001);
    push(28'h0000002);
    chk("empty", 1'h0, fifo_empty);
    @(negedge clk_sys);
    core_valid = 1'b1;
    core_data = 28'h0000003;
    repeat (2) @(negedge clk_sys);
    chk("ready", 1'h0, core_ready);
    rd(`AHBP_ADDR_FIFO, 1'h1, 1'h1);
    core_valid = 1'b0;
    chk("word1", 28'h1, q);
    chk("oe", 1'h1, oe);
    rd(`AHBP_ADDR_FIFO, 1'h1, 1'h1);
    chk("word2", 28'h2, q);
    rd(4'h3, 1'h1, 1'h0);
    chk("dummy", 28'h1234567, q);
    rd(`AHBP_ADDR_FIFO, 1'h1, 1'h1);
    chk("word3", 28'h3, q);
    chk("drained", 1'h1, fifo_empty);
    $display("test fill done");
  endtask
  task automatic t_drive();
    push(28'hBEEF123);
    rd(`AHBP_ADDR_FIFO, 1'h0, 1'h1);
    repeat (10) @(negedge clk_sys);
    chk("oe", 1'h1, data_oe);
    chk("held", 28'hBEEF123, data_out);
    rd(4'h3, 1'h1, 1'h0);
    chk("reg", 28'h1234567, q);
    chk("oe off", 1'h0, data_oe);
    $display("test drive done");
  endtask
  task automatic t_wr();
    wr(4'h5, 28'h7654321, 1'h0);
    chk("refused", 28'h0, wcnt);
    wr(4'h5, 28'h7654321, 1'h1);
    chk("count", 28'h1, wcnt);
    chk("addr", 4'h5, wa);
    chk("data", 28'h7654321, wd);
    $display("test write done");
  endtask
  task automatic t_half();
    wr(`AHBP_ADDR_MODE, `AHBP_MODE_HALF, 1'h1);
    chk("half", 1'h1, half_mode);
    push(28'hABCDEF1);
    rd(`AHBP_ADDR_FIFO, 1'h1, 1'h1);
    chk("lower", 16'hDEF1, q[15:0]);
    chk("empty", 1'h1, fifo_empty);
    rd(`AHBP_ADDR_FIFO, 1'h1, 1'h0);
    chk("upper", 12'hABC, q[11:0]);
    wr(4'h6, 28'h0005678, 1'h1);
    wr(4'h6, 28'h000F123, 1'h1);
    chk("pair", 28'h1235678, wd);
    wr(`AHBP_ADDR_MODE, 28'h0, 1'h1);
    wr(`AHBP_ADDR_MODE, 28'h0, 1'h1);
    chk("full", 1'h0, half_mode);
    $display("test half done");
  endtask
  task automatic t_blank();
    master_reset = 1'b1;
    repeat (5) @(negedge clk_sys);
    chk("blank", 1'h0, hit_accept);
    master_reset = 1'b0;
    @(negedge clk_sys);
    chk("still", 1'h0, hit_accept);
    repeat (4) @(negedge clk_sys);
    chk("tail", 1'h0, hit_accept);
    repeat (2) @(negedge clk_sys);
    chk("accept", 1'h1, hit_accept);
    $display("test blank done");
  endtask
  task automatic t_freeze();
    @(negedge clk_sys);
    ce = 1'b0;
    core_valid = 1'b1;
    core_data = 28'h0000009;
    repeat (3) @(negedge clk_sys);
    chk("frozen", 1'h1, fifo_empty);
    ce = 1'b1;
    @(negedge clk_sys);
    core_valid = 1'b0;
    rd(`AHBP_ADDR_FIFO, 1'h1, 1'h1);
    chk("thawed", 28'h9, q);
    $display("test freeze done");
  endtask
  task automatic t_reset();
    wr(`AHBP_ADDR_MODE, `AHBP_MODE_HALF, 1'h1);
    push(28'h0000007);
    @(negedge clk_sys);
    srst = 1'b1;
    repeat (4) @(negedge clk_sys);
    srst = 1'b0;
    chk("mode reset", 1'h0, half_mode);
    chk("empty reset", 1'h1, fifo_empty);
    rd(4'h3, 1'h1, 1'h0);
    chk("full word", 28'h1234567, q);
    $display("test reset done");
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    repeat (4) @(negedge clk_sys);
    srst = 1'b0;
    chk("mode", 1'h0, half_mode);
    t_freeze();
    t_fill();
    t_drive();
    t_wr();
    t_half();
    t_blank();
    t_reset();
    chk("bad read", 1'h0, bad_rd);
    close_out();
  end
  initial begin
    #2000000;
    fails++;
    close_out();
  end
endmodule
`default_nettype wire
